/* File: rtl/ssp_pkg.sv */
/*
  ssp_pkg: shared constants and types for the five-channel synchronous
  serial pin routing block.
  assumes: pin vector order is port 6 bits 0..7, port 7 bits 0..7, port 9 bits 0..7.
*/
package ssp_pkg;
  // ==========================================================================
  // sizes
  localparam int NUM_CH    = 5;
  localparam int NUM_PINS  = 24;
  localparam int CHAR_BITS = 8;

  // ==========================================================================
  // routing masks, bit positions in the 24-bit pin vector
  // output functions that also need the low peripheral-select bit at 0
  localparam logic [NUM_PINS-1:0] PSL_OUT_MASK = 24'h050dbb;
  // input functions that also need the low peripheral-select bit at 0
  localparam logic [NUM_PINS-1:0] PSL_IN_MASK  = 24'h380000;
  // extra peripheral-select bits that matter, port 7 only
  localparam logic [7:0]          PSC_MASK_P7  = 8'h0d;
  // pins whose driver is n-channel only
  localparam logic [NUM_PINS-1:0] OD_FIXED_MASK = 24'h000100;

  typedef logic [4:0] ssp_pin_idx_type;
  localparam ssp_pin_idx_type TX_PIN  [NUM_CH] = '{5'h03, 5'h07, 5'h08, 5'h12, 5'h16};
  localparam ssp_pin_idx_type RX_PIN  [NUM_CH] = '{5'h02, 5'h06, 5'h09, 5'h11, 5'h17};
  localparam ssp_pin_idx_type CLK_PIN [NUM_CH] = '{5'h01, 5'h05, 5'h0a, 5'h10, 5'h15};
  localparam ssp_pin_idx_type HS_PIN  [NUM_CH] = '{5'h00, 5'h04, 5'h0b, 5'h13, 5'h14};

  // ==========================================================================
  // reset values and counts
  localparam logic [7:0] DIR_RST      = 8'h00;
  localparam logic [7:0] FSEL_RST     = 8'h00;
  localparam logic [3:0] LAST_BIT_CNT = 4'h7;

  // ==========================================================================
  // types
  typedef struct packed {
    logic clk_pol;
    logic msb_first;
    logic clk_in_en;
    logic rx_in_en;
  } ssp_chan_cfg_type;

  typedef struct packed {
    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] oe;
  } ssp_pin_drv_type;

  typedef enum logic [1:0] {
    LINK_IDLE  = 2'b00,
    LINK_SHIFT = 2'b01,
    LINK_DONE  = 2'b11
  } ssp_link_state_type;
endpackage

/* File: rtl/ssp_sync_serial_pins.sv */
/*
  ssp_sync_serial_pins: pin routing, protect-guarded port 9 registers and
  an 8-bit clock-synchronous shifter for five channels.
  assumes: configuration values are plain ports; link_clk_i oversamples the
  serial clock pins (external clock only); srst_i is synchronous to sys_clk_i.
*/
// Operation
// - routed transmit pin idles high before the first transmission and after each one
// - open-drain transmit pin floats instead of driving high while idle
// - each channel has a clock polarity select choosing shift and sample edges
// - each channel has a bit order select for 8-bit characters
// - channel 2 transmit pin only pulls low or floats
// - polarity 0 shifts out on falling edge, samples on rising
// - bit order 0 sends lsb first, 1 sends msb first
module ssp_sync_serial_pins (
  input  wire logic                                 sys_clk_i,
  input  wire logic                                 srst_i,
  input  wire logic                                 link_clk_i,
  input  wire logic [7:0]                           port6_direction_i,
  input  wire logic [7:0]                           port7_direction_i,
  input  wire logic [7:0]                           func_select_reg_a_i,
  input  wire logic [7:0]                           func_select_reg_b_i,
  input  wire logic [7:0]                           periph_select_low_a_i,
  input  wire logic [7:0]                           periph_select_low_b_i,
  input  wire logic [7:0]                           periph_select_low_d_i,
  input  wire logic [7:0]                           periph_select_extra_i,
  input  wire logic                                 protect_wr_i,
  input  wire logic                                 port_protect_unlock_bit_i,
  input  wire logic                                 port9_dir_wr_i,
  input  wire logic                                 func_sel_d_wr_i,
  input  wire logic                                 other_wr_i,
  input  wire logic [7:0]                           guarded_wdata_i,
  input  wire logic [ssp_pkg::NUM_CH-1:0]           mode_enable_i,
  input  wire logic [ssp_pkg::NUM_CH-1:0]           clock_edge_polarity_sel_i,
  input  wire logic [ssp_pkg::NUM_CH-1:0]           bit_order_sel_i,
  input  wire logic [ssp_pkg::NUM_CH-1:0]           open_drain_sel_i,
  input  wire logic [ssp_pkg::NUM_CH-1:0]           rx_ready_i,
  input  wire logic [ssp_pkg::NUM_CH-1:0]           tx_start_i,
  input  wire logic [ssp_pkg::NUM_CH-1:0][7:0]      tx_data_i,
  input  wire logic [ssp_pkg::NUM_PINS-1:0]         pin_i,
  output logic      [ssp_pkg::NUM_PINS-1:0]         pin_o,
  output logic      [ssp_pkg::NUM_PINS-1:0]         pin_oe_o,
  output logic      [7:0]                           port9_direction_o,
  output logic      [7:0]                           func_select_reg_d_o,
  output logic                                      protect_armed_o,
  output logic      [ssp_pkg::NUM_CH-1:0]           busy_o,
  output logic      [ssp_pkg::NUM_CH-1:0]           rx_done_o,
  output logic      [ssp_pkg::NUM_CH-1:0][7:0]      rx_data_o
);
  import ssp_pkg::*;
  // ==========================================================================
  // protect-guarded registers (system clock)
  logic       armed_reg, armed_next;
  logic [7:0] p9dir_reg, p9dir_next;
  logic [7:0] fsd_reg, fsd_next;
  logic       any_wr;
  always_comb begin
    any_wr     = port9_dir_wr_i | func_sel_d_wr_i | other_wr_i;
    armed_next = armed_reg;
    p9dir_next = p9dir_reg;
    fsd_next   = fsd_reg;
    if (protect_wr_i) begin
      armed_next = port_protect_unlock_bit_i;
    end else if (any_wr) begin
      armed_next = 1'b0;
    end
    if (armed_reg && !protect_wr_i && port9_dir_wr_i) begin
      p9dir_next = guarded_wdata_i;
    end
    if (armed_reg && !protect_wr_i && func_sel_d_wr_i) begin
      fsd_next = guarded_wdata_i;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      armed_reg <= 1'b0;
      p9dir_reg <= DIR_RST;
      fsd_reg   <= FSEL_RST;
    end else begin
      armed_reg <= armed_next;
      p9dir_reg <= p9dir_next;
      fsd_reg   <= fsd_next;
    end
  end
  assign port9_direction_o   = p9dir_reg;
  assign func_select_reg_d_o = fsd_reg;
  assign protect_armed_o     = armed_reg;

  // ==========================================================================
  // pin routing and drivers (system clock)
  logic [NUM_PINS-1:0] out_sel;
  logic [NUM_PINS-1:0] in_sel;
  logic [NUM_PINS-1:0] psl_all;
  ssp_pin_drv_type     drv_reg, drv_next;
  logic [NUM_CH-1:0]   tx_meta_reg, tx_lvl_reg;
  ssp_chan_cfg_type [NUM_CH-1:0] cfg_reg, cfg_next;
  logic [NUM_CH-1:0]   tx_lvl_link;
  always_comb begin
    psl_all = {periph_select_low_d_i, periph_select_low_b_i, periph_select_low_a_i};
    out_sel = {fsd_reg, func_select_reg_b_i, func_select_reg_a_i}
            & ~(psl_all & PSL_OUT_MASK)
            & ~{8'h00, periph_select_extra_i & PSC_MASK_P7, 8'h00};
    in_sel  = ~{p9dir_reg, port7_direction_i, port6_direction_i}
            & ~{fsd_reg, func_select_reg_b_i, func_select_reg_a_i}
            & ~(psl_all & PSL_IN_MASK);
    drv_next = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      cfg_next[c].clk_pol   = clock_edge_polarity_sel_i[c];
      cfg_next[c].msb_first = bit_order_sel_i[c];
      cfg_next[c].clk_in_en = in_sel[CLK_PIN[c]] & mode_enable_i[c];
      cfg_next[c].rx_in_en  = in_sel[RX_PIN[c]] & mode_enable_i[c];
      // transmit idles high, or floats when open drain
      if (out_sel[TX_PIN[c]] && mode_enable_i[c]) begin
        if (open_drain_sel_i[c]) begin
          drv_next.oe[TX_PIN[c]] = ~tx_lvl_reg[c];
        end else begin
          drv_next.level[TX_PIN[c]] = tx_lvl_reg[c];
          drv_next.oe[TX_PIN[c]]    = 1'b1;
        end
      end
      // only external clock is supported, so an output clock pin rests at idle level
      if (out_sel[CLK_PIN[c]] && mode_enable_i[c]) begin
        drv_next.level[CLK_PIN[c]] = ~clock_edge_polarity_sel_i[c];
        drv_next.oe[CLK_PIN[c]]    = 1'b1;
      end
      if (out_sel[HS_PIN[c]] && mode_enable_i[c]) begin
        drv_next.level[HS_PIN[c]] = ~rx_ready_i[c];
        drv_next.oe[HS_PIN[c]]    = 1'b1;
      end
    end
    drv_next.oe    = drv_next.oe & ~(OD_FIXED_MASK & drv_next.level);
    drv_next.level = drv_next.level & ~OD_FIXED_MASK;
  end
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      drv_reg     <= '0;
      cfg_reg     <= '0;
      tx_meta_reg <= '1;
      tx_lvl_reg  <= '1;
    end else begin
      drv_reg     <= drv_next;
      cfg_reg     <= cfg_next;
      tx_meta_reg <= tx_lvl_link;
      tx_lvl_reg  <= tx_meta_reg;
    end
  end
  assign pin_o    = drv_reg.level;
  assign pin_oe_o = drv_reg.oe;

  // ==========================================================================
  // transfer handshake (system clock); data held stable while busy
  logic [NUM_CH-1:0]      req_reg, req_next;
  logic [NUM_CH-1:0]      ack_meta_reg, ack_s_reg, ack_d_reg;
  logic [NUM_CH-1:0][7:0] hold_reg, hold_next;
  logic [NUM_CH-1:0][7:0] rxd_reg, rxd_next;
  logic [NUM_CH-1:0]      ack_link;
  logic [NUM_CH-1:0][7:0] rx_word_link;
  always_comb begin
    req_next  = req_reg;
    hold_next = hold_reg;
    rxd_next  = rxd_reg;
    for (int c = 0; c < NUM_CH; c++) begin
      if (tx_start_i[c] && !busy_o[c] && mode_enable_i[c]) begin
        req_next[c]  = ~req_reg[c];
        hold_next[c] = tx_data_i[c];
      end
      if (ack_s_reg[c] != ack_d_reg[c]) begin
        rxd_next[c] = rx_word_link[c];
      end
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      req_reg      <= '0;
      hold_reg     <= '0;
      rxd_reg      <= '0;
      ack_meta_reg <= '0;
      ack_s_reg    <= '0;
      ack_d_reg    <= '0;
    end else begin
      req_reg      <= req_next;
      hold_reg     <= hold_next;
      rxd_reg      <= rxd_next;
      ack_meta_reg <= ack_link;
      ack_s_reg    <= ack_meta_reg;
      ack_d_reg    <= ack_s_reg;
    end
  end
  assign busy_o    = req_reg ^ ack_d_reg;
  assign rx_done_o = ack_s_reg ^ ack_d_reg;
  assign rx_data_o = rxd_reg;

  // ==========================================================================
  // link domain: synchronisers
  logic                   lrst_meta_reg, lrst_reg;
  logic [NUM_CH-1:0]      lreq_meta_reg, lreq_reg;
  logic [NUM_CH-1:0]      clk_meta_reg, clk_s_reg, clk_d_reg;
  logic [NUM_CH-1:0]      rx_meta_reg, rx_s_reg;
  ssp_chan_cfg_type [NUM_CH-1:0] lcfg_meta_reg, lcfg_reg;
  logic [NUM_CH-1:0]      pin_clk_raw, pin_rx_raw;
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      pin_clk_raw[c] = pin_i[CLK_PIN[c]];
      pin_rx_raw[c]  = pin_i[RX_PIN[c]];
    end
  end
  always_ff @(posedge link_clk_i) begin
    lrst_meta_reg <= srst_i;
    lrst_reg      <= lrst_meta_reg;
    lreq_meta_reg <= req_reg;
    lreq_reg      <= lreq_meta_reg;
    clk_meta_reg  <= pin_clk_raw;
    clk_s_reg     <= clk_meta_reg;
    clk_d_reg     <= clk_s_reg;
    rx_meta_reg   <= pin_rx_raw;
    rx_s_reg      <= rx_meta_reg;
    lcfg_meta_reg <= cfg_reg;
    lcfg_reg      <= lcfg_meta_reg;
  end

  // ==========================================================================
  // link domain: shifters
  ssp_link_state_type [NUM_CH-1:0] st_reg, st_next;
  logic [NUM_CH-1:0][7:0] sr_reg, sr_next, rsr_reg, rsr_next, rw_reg, rw_next;
  logic [NUM_CH-1:0][3:0] cnt_reg, cnt_next;
  logic [NUM_CH-1:0]      seen_reg, seen_next, ack_reg, ack_next, txb_reg, txb_next;
  logic [NUM_CH-1:0]      rise, fall, shift_edge, sample_edge;
  always_comb begin
    st_next  = st_reg;
    sr_next  = sr_reg;
    rsr_next = rsr_reg;
    rw_next  = rw_reg;
    cnt_next = cnt_reg;
    seen_next = seen_reg;
    ack_next = ack_reg;
    txb_next = txb_reg;
    for (int c = 0; c < NUM_CH; c++) begin
      rise[c] = lcfg_reg[c].clk_in_en & clk_s_reg[c] & ~clk_d_reg[c];
      fall[c] = lcfg_reg[c].clk_in_en & ~clk_s_reg[c] & clk_d_reg[c];
      // polarity picks shift and sample edges
      shift_edge[c]  = lcfg_reg[c].clk_pol ? rise[c] : fall[c];
      sample_edge[c] = lcfg_reg[c].clk_pol ? fall[c] : rise[c];
      case (st_reg[c])
        LINK_IDLE: begin
          if (lreq_reg[c] != seen_reg[c]) begin
            seen_next[c] = lreq_reg[c];
            sr_next[c]   = hold_reg[c];
            cnt_next[c]  = 4'h0;
            st_next[c]   = LINK_SHIFT;
          end
        end
        LINK_SHIFT: begin
          if (shift_edge[c]) begin
            txb_next[c] = lcfg_reg[c].msb_first ? sr_reg[c][7] : sr_reg[c][0];
            sr_next[c]  = lcfg_reg[c].msb_first ? {sr_reg[c][6:0], 1'b1} : {1'b1, sr_reg[c][7:1]};
          end
          if (sample_edge[c]) begin
            rsr_next[c] = lcfg_reg[c].msb_first ? {rsr_reg[c][6:0], rx_s_reg[c] & lcfg_reg[c].rx_in_en}
                                                : {rx_s_reg[c] & lcfg_reg[c].rx_in_en, rsr_reg[c][7:1]};
            cnt_next[c] = cnt_reg[c] + 4'h1;
            if (cnt_reg[c] == LAST_BIT_CNT) begin
              rw_next[c] = rsr_next[c];
              st_next[c] = LINK_DONE;
            end
          end
        end
        LINK_DONE: begin
          txb_next[c] = 1'b1;
          ack_next[c] = ~ack_reg[c];
          st_next[c]  = LINK_IDLE;
        end
        default: st_next[c] = LINK_IDLE;
      endcase
    end
  end
  always_ff @(posedge link_clk_i) begin
    if (lrst_reg) begin
      st_reg   <= {NUM_CH{LINK_IDLE}};
      sr_reg   <= '0;
      rsr_reg  <= '0;
      rw_reg   <= '0;
      cnt_reg  <= '0;
      seen_reg <= '0;
      ack_reg  <= '0;
      txb_reg  <= '1;
    end else begin
      st_reg   <= st_next;
      sr_reg   <= sr_next;
      rsr_reg  <= rsr_next;
      rw_reg   <= rw_next;
      cnt_reg  <= cnt_next;
      seen_reg <= seen_next;
      ack_reg  <= ack_next;
      txb_reg  <= txb_next;
    end
  end
  assign tx_lvl_link  = txb_reg;
  assign ack_link     = ack_reg;
  assign rx_word_link = rw_reg;

  // ==========================================================================
  // checks
  a_guard_needs_unlock: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (port9_dir_wr_i && !armed_reg) |=> $stable(p9dir_reg)) else $error("guarded write without unlock");
  a_unlock_one_shot: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (armed_reg && other_wr_i && !protect_wr_i) |=> !armed_reg) else $error("unlock outlived next write");
  a_tx_idle_high: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (mode_enable_i[0] && out_sel[3] && !open_drain_sel_i[0] && tx_lvl_reg[0]) |=> (pin_oe_o[3] && pin_o[3]))
    else $error("idle transmit pin not high");
  a_tx_od_float: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (mode_enable_i[1] && open_drain_sel_i[1] && tx_lvl_reg[1]) |=> !pin_oe_o[7]) else $error("open drain driven high");
  a_od_pin_low_only: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    pin_oe_o[8] |-> !pin_o[8]) else $error("channel 2 transmit drove high");
  a_out_needs_select: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ##1 pin_oe_o[3] |-> $past(func_select_reg_a_i[3] && !periph_select_low_a_i[3])) else $error("output not selected");
  a_sample_edge_count: assert property (@(posedge link_clk_i) disable iff (lrst_reg)
    (st_reg[0] == LINK_SHIFT && !lcfg_reg[0].clk_pol && rise[0] && cnt_reg[0] != LAST_BIT_CNT)
    |=> cnt_reg[0] == $past(cnt_reg[0]) + 4'h1) else $error("rising edge did not sample");
  a_pol_swaps_edge: assert property (@(posedge link_clk_i) disable iff (lrst_reg)
    (st_reg[0] == LINK_SHIFT && lcfg_reg[0].clk_pol && rise[0]) |=> $stable(cnt_reg[0]))
    else $error("polarity 1 sampled on rising edge");
  a_lsb_first_out: assert property (@(posedge link_clk_i) disable iff (lrst_reg)
    (st_reg[0] == LINK_SHIFT && shift_edge[0] && !lcfg_reg[0].msb_first) |=> txb_reg[0] == $past(sr_reg[0][0]))
    else $error("lsb not sent first");
  a_msb_first_out: assert property (@(posedge link_clk_i) disable iff (lrst_reg)
    (st_reg[0] == LINK_SHIFT && shift_edge[0] && lcfg_reg[0].msb_first) |=> txb_reg[0] == $past(sr_reg[0][7]))
    else $error("msb not sent first");
endmodule

/* File: dv/ssp_serial_partner.sv */
/*
  ssp_serial_partner: behavioural external device on one channel's clock,
  receive and transmit pins, supplying the serial clock (external clock).
  assumes: the bench routes sclk_o and rx_line_o onto the channel's input pins
  and hands back the resolved transmit wire level on tx_line_i.
*/
module ssp_serial_partner (
  input  wire logic       clk_pol_i,
  input  wire logic       go_i,
  input  wire logic [7:0] rx_bits_i,
  input  wire logic       tx_line_i,
  output logic            sclk_o,
  output logic            rx_line_o,
  output logic [7:0]      tx_bits_o,
  output logic            frame_done_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // half period is long so the pin synchronisers settle well inside a bit
  localparam int HALF_NS = 100;
  logic in_frame;

  // ==========================================================================
  // idle clock
  initial begin
    in_frame     = 1'b0;
    sclk_o       = 1'b1;
    rx_line_o    = 1'b1;
    tx_bits_o    = 8'h00;
    frame_done_o = 1'b0;
  end

  always @(clk_pol_i) begin
    if (!in_frame) begin
      sclk_o = ~clk_pol_i;
    end
  end

  // ==========================================================================
  // frame: bits kept in time order
  // shift edge, sample edge
  always @(posedge go_i) begin
    in_frame = 1'b1;
    for (int i = 0; i < 8; i++) begin
      sclk_o    = clk_pol_i;
      rx_line_o = rx_bits_i[i];
      #HALF_NS;
      sclk_o       = ~clk_pol_i;
      tx_bits_o[i] = tx_line_i;
      #HALF_NS;
    end
    // released line must not keep showing the last bit
    rx_line_o    = ~rx_line_o;
    in_frame     = 1'b0;
    frame_done_o = 1'b1;
    #10;
    frame_done_o = 1'b0;
  end
endmodule

/* File: dv/ssp_sync_serial_pins_tb.sv */
/*
  ssp_sync_serial_pins_tb: self-checking bench for the pin routing block.
  assumes: pull-ups on all pins; channel 0 talks to the partner model.
*/
module ssp_sync_serial_pins_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ssp_pkg::*;
  logic sys_clk = 0, link_clk = 0, srst = 1, go = 0;
  logic [7:0] p6d, p7d, fsa, fsb, psla, pslb, psld, periph_select_extra, gdata, rx_bits;
  logic pwr, unlock, p9wr, fsdwr, owr, sclk, rx_line, frame_done;
  logic [NUM_CH-1:0] mode, pol, order, od, rdy, start, busy, rx_done;
  logic [NUM_CH-1:0][7:0] txd, rxd;
  logic [NUM_PINS-1:0] pin_o, pin_oe, pin_in;
  logic [7:0] p9d_o, fsd_o, tx_bits;
  logic armed;
  logic [7:0] exp_rx_q[$], exp_tx_q[$];
  int mismatches = 0, num_checks = 0, cycles = 0;
  logic [31:0] seed = 32'h8f29e810;

  always #5 sys_clk = ~sys_clk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  // ==========================================================================
  // pin wires
  always_comb begin
    for (int k = 0; k < NUM_PINS; k++) pin_in[k] = pin_oe[k] ? pin_o[k] : 1'b1;
    if (!pin_oe[1]) pin_in[1] = sclk;
    if (!pin_oe[2]) pin_in[2] = rx_line;
  end

  ssp_sync_serial_pins ssp_sync_serial_pins_inst (
    .sys_clk_i(sys_clk), .srst_i(srst), .link_clk_i(link_clk),
    .port6_direction_i(p6d), .port7_direction_i(p7d),
    .func_select_reg_a_i(fsa), .func_select_reg_b_i(fsb),
    .periph_select_low_a_i(psla), .periph_select_low_b_i(pslb),
    .periph_select_low_d_i(psld), .periph_select_extra_i(periph_select_extra),
    .protect_wr_i(pwr), .port_protect_unlock_bit_i(unlock),
    .port9_dir_wr_i(p9wr), .func_sel_d_wr_i(fsdwr), .other_wr_i(owr),
    .guarded_wdata_i(gdata), .mode_enable_i(mode),
    .clock_edge_polarity_sel_i(pol), .bit_order_sel_i(order),
    .open_drain_sel_i(od), .rx_ready_i(rdy), .tx_start_i(start),
    .tx_data_i(txd), .pin_i(pin_in), .pin_o(pin_o), .pin_oe_o(pin_oe),
    .port9_direction_o(p9d_o), .func_select_reg_d_o(fsd_o),
    .protect_armed_o(armed), .busy_o(busy), .rx_done_o(rx_done),
    .rx_data_o(rxd)
  );

  ssp_serial_partner ssp_serial_partner_inst (
    .clk_pol_i(pol[0]), .go_i(go), .rx_bits_i(rx_bits), .tx_line_i(pin_in[3]),
    .sclk_o(sclk), .rx_line_o(rx_line), .tx_bits_o(tx_bits),
    .frame_done_o(frame_done)
  );

  // ==========================================================================
  // helpers
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // arm: unlock first; spoil: another write lands before the guarded one
  task automatic gwrite(input logic arm, input logic spoil, input logic to_dir, input logic [7:0] d);
    if (arm) begin
      @(posedge sys_clk); pwr <= 1'b1; unlock <= 1'b1;
    end
    if (spoil) begin
      @(posedge sys_clk); pwr <= 1'b0; owr <= 1'b1;
    end
    @(posedge sys_clk); pwr <= 1'b0; owr <= 1'b0; p9wr <= to_dir; fsdwr <= !to_dir; gdata <= d;
    @(posedge sys_clk); p9wr <= 1'b0; fsdwr <= 1'b0;
    settle(1);
  endtask

  task automatic xfer(input logic p, input logic o);
    logic [7:0] td, rd, ex_tx, ex_rx;
    td = $random(seed);
    rd = $random(seed);
    for (int i = 0; i < 8; i++) begin
      ex_tx[i] = o ? td[7-i] : td[i];
      ex_rx[o ? 7-i : i] = rd[i];
    end
    @(posedge sys_clk); pol[0] <= p; order[0] <= o; rx_bits <= rd;
    settle(8);
    exp_rx_q.push_back(ex_rx);
    exp_tx_q.push_back(ex_tx);
    @(posedge sys_clk); start[0] <= 1'b1; txd[0] <= td;
    @(posedge sys_clk); start[0] <= 1'b0;
    settle(2);
    check({7'h00, busy[0]}, 8'h01);
    @(posedge sys_clk); go <= 1'b1;
    @(posedge sys_clk); go <= 1'b0;
    for (int k = 0; k < 400 && (exp_rx_q.size() + exp_tx_q.size()) != 0; k++) settle(1);
    check(exp_rx_q.size() + exp_tx_q.size(), 8'h00);
    check({7'h00, busy[0]}, 8'h00);
  endtask

  // ==========================================================================
  // result watchers
  always @(negedge sys_clk) begin
    if (rx_done[0] === 1'b1) begin
      // the word reaches the data register one cycle after the done pulse
      @(negedge sys_clk);
      if (exp_rx_q.size() != 0) check(rxd[0], exp_rx_q.pop_front());
      else check(8'h01, 8'h00);
    end
  end

  always @(posedge frame_done) begin
    if (exp_tx_q.size() != 0) check(tx_bits, exp_tx_q.pop_front());
    else check(8'h01, 8'h00);
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    {p6d, p7d, fsa, fsb, psla, pslb, psld, periph_select_extra, gdata, rx_bits} = '0;
    {pwr, unlock, p9wr, fsdwr, owr} = '0;
    {mode, pol, order, od, rdy, start} = '0;
    txd = '0;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    settle(4);
    gwrite(1'b0, 1'b0, 1'b1, 8'h5a);
    check(p9d_o, 8'h00);
    gwrite(1'b1, 1'b0, 1'b1, 8'ha5);
    check(p9d_o, 8'ha5);
    check({7'h00, armed}, 8'h00);
    gwrite(1'b1, 1'b1, 1'b1, 8'hff);
    check(p9d_o, 8'ha5);
    @(posedge sys_clk); pwr <= 1'b1; unlock <= 1'b1;
    @(posedge sys_clk); pwr <= 1'b0;
    settle(1);
    check({7'h00, armed}, 8'h01);
    @(posedge sys_clk); p6d <= 8'h00; mode <= 5'h1f;
    @(posedge sys_clk); fsa <= 8'h89; fsb <= 8'h01;
    gwrite(1'b1, 1'b0, 1'b0, 8'h04);
    check(fsd_o, 8'h04);
    settle(2);
    check({pin_oe[3], pin_o[3], pin_oe[18], pin_o[18]}, 8'h0f);
    check({pin_oe[8], pin_in[8]}, 8'h01);
    check({pin_oe[0], pin_o[0]}, 8'h03);
    @(posedge sys_clk); rdy[0] <= 1'b1;
    psla <= 8'h08;
    settle(3);
    check({pin_oe[0], pin_o[0], pin_oe[3]}, 8'h04);
    @(posedge sys_clk); psla <= 8'h00;
    od[1] <= 1'b1;
    settle(3);
    check({pin_oe[7], pin_in[7], pin_oe[3], pin_o[3]}, 8'h07);
    for (int n = 0; n < 4; n++) xfer(n[1], n[0]);
    finish_test();
  end
endmodule
